// *** rtl/osd_pkg.sv ***
// Package for the output-state and loop-divider register bank.
// Assumes one 200 MHz clock and a byte-wide register port.
`default_nettype none
package osd_pkg;
	localparam int          NUM_OUT        = 8;
	localparam int          CLK_PERIOD_PS  = 5000;
	// Divider, misc and output-enable register addresses
	localparam logic [7:0]  ADDR_FB_HI     = 8'h00;
	localparam logic [7:0]  ADDR_FB_LO     = 8'h01;
	localparam logic [7:0]  ADDR_SFB_LO    = 8'h02;
	localparam logic [7:0]  ADDR_SFB_MSB   = 8'h03;
	localparam logic [7:0]  ADDR_REF_HI    = 8'h04;
	localparam logic [7:0]  ADDR_REF_LO    = 8'h05;
	localparam logic [7:0]  ADDR_SYN_MSB   = 8'h08;
	localparam logic [7:0]  ADDR_SYN_LO    = 8'h09;
	localparam logic [7:0]  ADDR_DBL_PRE   = 8'h0c;
	localparam logic [7:0]  ADDR_MISC      = 8'h1f;
	localparam logic [7:0]  ADDR_OUT_EN    = 8'h76;
	// Output state registers, order A0 A1 A2 B0 B1 C0 C1 D
	localparam logic [7:0]  ADDR_OUT_STATE [NUM_OUT] = '{8'h2c, 8'h2d, 8'h2e, 8'h3c, 8'h3d, 8'h4c, 8'h4d, 8'h5c};
	// Field positions
	localparam int          POS_WIN        = 5;
	localparam int          POS_SFB_OFF    = 4;
	localparam int          POS_MSB        = 7;
	localparam int          POS_DBL        = 7;
	localparam int          POS_SRC        = 6;
	localparam int          POS_OUT_PD     = 7;
	localparam int          POS_OUT_BIAS   = 5;
	localparam int          POS_OUT_STYLE  = 4;
	localparam int          POS_OUT_AMP    = 2;
	// Reset values
	localparam logic [11:0] RST_FB_DIV     = 12'hc00;
	localparam logic [2:0]  RST_WIN        = 3'h5;
	localparam logic [8:0]  RST_SFB_DIV    = 9'h01e;
	localparam logic [11:0] RST_REF_DIV    = 12'hc00;
	localparam logic [8:0]  RST_SYN_DIV    = 9'h01e;
	localparam logic [5:0]  RST_PRE_DIV    = 6'h00;
	localparam logic [7:0]  RST_MISC       = 8'h00;
	localparam logic [1:0]  RST_AMP        = 2'h0;
	// Swing per amplitude step
	localparam logic [9:0]  AMP_STEP_MV    = 10'h0fa;

	typedef struct packed {
		logic       pd;
		logic       bias;
		logic       lvpecl;
		logic [1:0] amp;
	} osd_out_cfg_t;

	typedef struct packed {
		logic       powered;
		logic       lvpecl;
		logic       toggle;
		logic [9:0] swing_mv;
	} osd_out_ctl_t;

	typedef struct packed {
		logic [2:0]  fb_win;
		logic [11:0] fb_div;
		logic        sfb_off;
		logic [8:0]  sfb_div;
		logic        byp;
		logic [2:0]  ref_win;
		logic [11:0] ref_div;
		logic [8:0]  syn_div;
		logic        dbl;
		logic        src;
		logic [5:0]  pre_div;
		logic [7:0]  misc;
	} osd_div_cfg_t;
endpackage : osd_pkg
`default_nettype wire

// *** rtl/osd_divider.sv ***
// Programmable integer divider producing a one-cycle tick.
// Ratio 0 or 1 passes every cycle; ratio is sampled continuously.
`default_nettype none
module osd_divider #(
	parameter int W = 12
) (
	input  wire logic         clk_in,   // System clock
	input  wire logic         rst_b_in, // Async reset, active low
	input  wire logic         en_in,    // Divider running
	input  wire logic [W-1:0] ratio_in, // Divide ratio
	output logic              tick_out, // One pulse per period
	output logic [W-1:0]      count_out // Current phase count
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         tick;
	} osd_div_st_t;

	osd_div_st_t st_q;
	osd_div_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (!en_in) begin
			st_d.cnt = '0;
		end else if (ratio_in <= W'(1)) begin
			st_d.cnt = '0;
			st_d.tick = 1'b1;
		end else if (st_q.cnt >= ratio_in - W'(1)) begin
			st_d.cnt = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + W'(1);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick_out  = st_q.tick;
	assign count_out = st_q.cnt;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// A shrunk ratio wraps at once from a higher count, so only settled ratios are checked
	chk_div_wrap_point: assert property ($rose(tick_out) && $past(ratio_in) > W'(1) &&
		$past(ratio_in, 2) == $past(ratio_in) |-> $past(count_out) == $past(ratio_in) - W'(1))
		else $error("Divider wrapped at wrong count");
	chk_div_idle_off: assert property (!en_in |=> !tick_out && count_out == '0)
		else $error("Disabled divider still ticking");
endmodule : osd_divider
`default_nettype wire

// *** rtl/osd_regs.sv ***
// Output state and loop divider register bank with divider cores.
// Assumes a synchronous byte register port driven by the serial front end.
//
// Functional notes
// - Amplitude code 00..11 selects 250..1000 mV swing, both formats, resets 00.
// - Power-down bit 1 powers output off, overriding format, enable and amplitude.
// - Format bit 0 selects LVDS, 1 selects LVPECL, reset 0.
// - Enable bit 0 holds output low, 1 lets it toggle, reset 0.
// - Eight independent field sets for outputs A0 A1 A2 B0 B1 C0 C1 D.
// - Lock sampling phase is offset by feedback and reference window fields.
// - Twelve-bit feedback divider divides by value 1..4095, resets to 3072.
// - Second feedback divider off bit 1 disables that divider, default 0.
// - Six-bit pre-divider 1..63, zero bypasses, no effect while doubler set.
`default_nettype none
module osd_regs (
	input  wire logic                 clk_in,              // System clock, 200 MHz
	input  wire logic                 rst_b_in,            // Async reset, active low
	input  wire logic                 wr_en_in,            // Register write strobe
	input  wire logic                 rd_en_in,            // Register read strobe
	input  wire logic [7:0]           addr_in,             // Register address
	input  wire logic [7:0]           wr_data_in,          // Write data
	output logic      [7:0]           rd_data_out,         // Read data, valid cycle after rd_en
	output osd_pkg::osd_out_ctl_t [7:0] sync_ref_output_out, // Per-output drive controls
	output logic      [7:0]           output_bias_out,     // Per-output bias request
	output osd_pkg::osd_div_cfg_t     div_cfg_out,         // Registered divider fields
	output logic                      fb_tick_out,         // First-loop feedback divider tick
	output logic                      second_fb_tick_out,  // Second feedback divider tick
	output logic                      synth_ref_tick_out,  // Second-loop reference tick
	output logic                      lock_sample_out      // Lock detector sample strobe
);
	typedef struct packed {
		osd_pkg::osd_div_cfg_t                 div;
		osd_pkg::osd_out_cfg_t [7:0]           outs;
		logic                  [7:0]           en;
		logic                  [7:0]           rd;
		logic                                  sample;
	} osd_state_t;

	osd_state_t  st_q;
	osd_state_t  st_d;
	logic [11:0] fb_count;
	logic        pre_tick;
	logic        pre_en;
	logic [11:0] sample_phase;

	function automatic logic [7:0] read_mux(input osd_state_t s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			osd_pkg::ADDR_FB_HI:   v = {s.div.fb_win, s.div.sfb_off, s.div.fb_div[11:8]};
			osd_pkg::ADDR_FB_LO:   v = s.div.fb_div[7:0];
			osd_pkg::ADDR_SFB_LO:  v = s.div.sfb_div[7:0];
			osd_pkg::ADDR_SFB_MSB: v = {s.div.sfb_div[8], 6'h00, s.div.byp};
			osd_pkg::ADDR_REF_HI:  v = {s.div.ref_win, 1'b0, s.div.ref_div[11:8]};
			osd_pkg::ADDR_REF_LO:  v = s.div.ref_div[7:0];
			osd_pkg::ADDR_SYN_MSB: v = {7'h00, s.div.syn_div[8]};
			osd_pkg::ADDR_SYN_LO:  v = s.div.syn_div[7:0];
			osd_pkg::ADDR_DBL_PRE: v = {s.div.dbl, s.div.src, s.div.pre_div};
			osd_pkg::ADDR_MISC:    v = s.div.misc;
			osd_pkg::ADDR_OUT_EN:  v = s.en;
			default: begin
				for (int i = 0; i < osd_pkg::NUM_OUT; i++) begin
					if (a == osd_pkg::ADDR_OUT_STATE[i]) begin
						v = {s.outs[i].pd, 1'b0, s.outs[i].bias, s.outs[i].lvpecl, s.outs[i].amp, 2'h0};
					end
				end
			end
		endcase
		return v;
	endfunction : read_mux

	always_comb begin
		st_d = st_q;
		if (wr_en_in) begin
			case (addr_in)
				osd_pkg::ADDR_FB_HI: begin
					st_d.div.fb_win       = wr_data_in[osd_pkg::POS_WIN +: 3];
					st_d.div.sfb_off      = wr_data_in[osd_pkg::POS_SFB_OFF];
					st_d.div.fb_div[11:8] = wr_data_in[3:0];
				end
				osd_pkg::ADDR_FB_LO:  st_d.div.fb_div[7:0] = wr_data_in;
				osd_pkg::ADDR_SFB_LO: st_d.div.sfb_div[7:0] = wr_data_in;
				osd_pkg::ADDR_SFB_MSB: begin
					st_d.div.sfb_div[8] = wr_data_in[osd_pkg::POS_MSB];
					st_d.div.byp        = wr_data_in[0];
				end
				osd_pkg::ADDR_REF_HI: begin
					st_d.div.ref_win       = wr_data_in[osd_pkg::POS_WIN +: 3];
					st_d.div.ref_div[11:8] = wr_data_in[3:0];
				end
				osd_pkg::ADDR_REF_LO:  st_d.div.ref_div[7:0] = wr_data_in;
				osd_pkg::ADDR_SYN_MSB: st_d.div.syn_div[8] = wr_data_in[0];
				osd_pkg::ADDR_SYN_LO:  st_d.div.syn_div[7:0] = wr_data_in;
				osd_pkg::ADDR_DBL_PRE: begin
					st_d.div.dbl     = wr_data_in[osd_pkg::POS_DBL];
					st_d.div.src     = wr_data_in[osd_pkg::POS_SRC];
					st_d.div.pre_div = wr_data_in[5:0];
				end
				osd_pkg::ADDR_MISC:   st_d.div.misc = wr_data_in;
				osd_pkg::ADDR_OUT_EN: st_d.en = wr_data_in;
				default: begin
					for (int i = 0; i < osd_pkg::NUM_OUT; i++) begin
						if (addr_in == osd_pkg::ADDR_OUT_STATE[i]) begin
							st_d.outs[i].pd     = wr_data_in[osd_pkg::POS_OUT_PD];
							st_d.outs[i].bias   = wr_data_in[osd_pkg::POS_OUT_BIAS];
							st_d.outs[i].lvpecl = wr_data_in[osd_pkg::POS_OUT_STYLE];
							st_d.outs[i].amp    = wr_data_in[osd_pkg::POS_OUT_AMP +: 2];
						end
					end
				end
			endcase
		end
		// Read returns pre-write contents when both strobes coincide
		if (rd_en_in) begin
			st_d.rd = read_mux(st_q, addr_in);
		end
		st_d.sample = (fb_count == sample_phase);
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q              <= '0;
			st_q.div.fb_win   <= osd_pkg::RST_WIN;
			st_q.div.fb_div   <= osd_pkg::RST_FB_DIV;
			st_q.div.sfb_div  <= osd_pkg::RST_SFB_DIV;
			st_q.div.ref_win  <= osd_pkg::RST_WIN;
			st_q.div.ref_div  <= osd_pkg::RST_REF_DIV;
			st_q.div.syn_div  <= osd_pkg::RST_SYN_DIV;
			st_q.div.pre_div  <= osd_pkg::RST_PRE_DIV;
			st_q.div.misc     <= osd_pkg::RST_MISC;
		end else begin
			st_q <= st_d;
		end
	end

	// Window fields set the sampling offset inside the feedback period
	assign sample_phase = {6'h00, st_q.div.fb_win, st_q.div.ref_win};

	osd_divider #(.W(12)) u_fb_div (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.en_in     (1'b1),
		.ratio_in  (st_q.div.fb_div),
		.tick_out  (fb_tick_out),
		.count_out (fb_count)
	);

	osd_divider #(.W(9)) u_sfb_div (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.en_in     (!st_q.div.sfb_off),
		.ratio_in  (st_q.div.sfb_div),
		.tick_out  (second_fb_tick_out),
		.count_out ()
	);

	// Doubler or zero code routes the reference straight through
	assign pre_en = !st_q.div.dbl && (st_q.div.pre_div != 6'h00);

	osd_divider #(.W(6)) u_pre_div (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.en_in     (pre_en),
		.ratio_in  (st_q.div.pre_div),
		.tick_out  (pre_tick),
		.count_out ()
	);

	assign synth_ref_tick_out = pre_en ? pre_tick : 1'b1;

	always_comb begin
		for (int i = 0; i < osd_pkg::NUM_OUT; i++) begin
			// Power-down masks format, enable and amplitude of the output, but not its bias
			sync_ref_output_out[i].powered  = !st_q.outs[i].pd;
			sync_ref_output_out[i].lvpecl   = !st_q.outs[i].pd && st_q.outs[i].lvpecl;
			sync_ref_output_out[i].toggle   = !st_q.outs[i].pd && st_q.en[7 - i];
			sync_ref_output_out[i].swing_mv = st_q.outs[i].pd ? 10'h000 :
				10'(amp_to_mv(st_q.outs[i].amp));
			output_bias_out[i] = st_q.outs[i].bias;
		end
	end

	function automatic logic [11:0] amp_to_mv(input logic [1:0] code);
		return 12'(osd_pkg::AMP_STEP_MV) * 12'({10'h000, code} + 12'h001);
	endfunction : amp_to_mv

	assign rd_data_out     = st_q.rd;
	assign div_cfg_out     = st_q.div;
	assign lock_sample_out = st_q.sample;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_fb_wr;
		wr_en_in && addr_in == osd_pkg::ADDR_FB_LO;
	endsequence

	chk_amp_swing_map: assert property (!st_q.outs[0].pd |->
		sync_ref_output_out[0].swing_mv == 10'h0fa * ({8'h00, st_q.outs[0].amp} + 10'h001))
		else $error("Swing does not follow amplitude code");
	chk_pd_override: assert property (st_q.outs[2].pd |->
		!sync_ref_output_out[2].toggle && !sync_ref_output_out[2].lvpecl && sync_ref_output_out[2].swing_mv == 10'h000)
		else $error("Powered-down output still active");
	chk_style_write: assert property (wr_en_in && addr_in == 8'h2c && !rd_en_in |=>
		st_q.outs[0].lvpecl == $past(wr_data_in[4])) else $error("Format bit not stored");
	chk_enable_hold: assert property (wr_en_in && addr_in == 8'h76 && !wr_data_in[1] |=>
		!sync_ref_output_out[6].toggle) else $error("Disabled output toggles");
	chk_out_indep: assert property (wr_en_in && addr_in == 8'h5c |=>
		$stable(st_q.outs[0]) && $stable(st_q.outs[6])) else $error("Write leaked to other output");
	chk_sample_phase: assert property (fb_count == sample_phase ##1 1'b1 |-> lock_sample_out)
		else $error("Lock sample missed its phase");
	chk_fb_ratio_load: assert property (s_fb_wr |=> st_q.div.fb_div[7:0] == $past(wr_data_in))
		else $error("Feedback divider not loaded");
	chk_sfb_off: assert property (st_q.div.sfb_off [*3] |-> !second_fb_tick_out)
		else $error("Disabled divider ticks");
	chk_pre_bypass: assert property (st_q.div.dbl || st_q.div.pre_div == 6'h00 |-> synth_ref_tick_out)
		else $error("Pre-divider not bypassed");
	chk_reserved_zero: assert property (rd_en_in && addr_in == 8'h08 |=> rd_data_out[7:1] == 7'h00)
		else $error("Reserved bits read nonzero");
endmodule : osd_regs
`default_nettype wire

// *** verification/osd_regs_tb.sv ***
// Self-checking bench for the output-state and loop-divider register bank.
// Drives the byte register port directly; no far-side model is needed.
`default_nettype none
module osd_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                        clk_in;
	logic                        rst_b_in;
	logic                        wr_en_in;
	logic                        rd_en_in;
	logic [7:0]                  addr_in;
	logic [7:0]                  wr_data_in;
	logic [7:0]                  rd_data_out;
	osd_pkg::osd_out_ctl_t [7:0] ctl;
	osd_pkg::osd_div_cfg_t       cfg;
	logic                        fb_t, sfb_t, syn_t, lock_t, clr;
	int                          fail_count, samples_checked, cycles;
	int                          n_fb, n_sfb, n_syn, n_lock;
	logic [7:0]                  ra [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0c, 8'h1f,
	                                         8'h76, 8'h5c};
	logic [7:0]                  rv [12] = '{8'hac, 8'h00, 8'h1e, 8'h00, 8'hac, 8'h00, 8'h00, 8'h1e, 8'h00, 8'h00,
	                                         8'h00, 8'h00};
	logic [7:0]                  wa [5] = '{8'h03, 8'h04, 8'h08, 8'h2c, 8'h10};
	logic [7:0]                  wv [5] = '{8'h81, 8'hef, 8'h01, 8'hbc, 8'h00};
	logic [2:0]                  k;
	logic [9:0]                  sw;
	logic [7:0]                  bias;

	osd_regs u_dut (
		.clk_in             (clk_in),
		.rst_b_in           (rst_b_in),
		.wr_en_in           (wr_en_in),
		.rd_en_in           (rd_en_in),
		.addr_in            (addr_in),
		.wr_data_in         (wr_data_in),
		.rd_data_out        (rd_data_out),
		.sync_ref_output_out(ctl),
		.output_bias_out    (bias),
		.div_cfg_out        (cfg),
		.fb_tick_out        (fb_t),
		.second_fb_tick_out (sfb_t),
		.synth_ref_tick_out (syn_t),
		.lock_sample_out    (lock_t)
	);

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test

	// Pulse counters; also cuts a hang short
	always @(posedge clk_in) begin
		cycles = cycles + 1;
		if (clr) begin
			n_fb = 0; n_sfb = 0; n_syn = 0; n_lock = 0;
		end else begin
			n_fb = n_fb + int'(fb_t); n_sfb = n_sfb + int'(sfb_t);
			n_syn = n_syn + int'(syn_t); n_lock = n_lock + int'(lock_t);
		end
		if (cycles == 40000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk_byte

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk_word

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_en_in   <= 1'b1;
		addr_in    <= a;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
		@(posedge clk_in);
		@(negedge clk_in);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		rd_en_in <= 1'b1;
		addr_in  <= a;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		@(posedge clk_in);
		@(negedge clk_in);
		chk_byte("read data", exp, rd_data_out);
	endtask : rd_chk

	// Long settle first: a shrunk ratio may let a running count wrap once
	task automatic count(input int n);
		repeat (4200) @(posedge clk_in);
		clr <= 1'b1;
		@(posedge clk_in);
		clr <= 1'b0;
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask : count

	initial begin
		rst_b_in = 1'b0; wr_en_in = 1'b0; rd_en_in = 1'b0; addr_in = 8'h00; wr_data_in = 8'h00;
		clr = 1'b0; cycles = 0; fail_count = 0; samples_checked = 0;
		n_fb = 0; n_sfb = 0; n_syn = 0; n_lock = 0;
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		foreach (ra[i]) rd_chk(ra[i], rv[i]);
		for (int i = 0; i < 8; i++) chk_word("out reset", {3'h0, 3'b100, 10'd250}, 16'(ctl[i]));
		$display("test reset values done");
		wr(8'h76, 8'ha5);
		for (int i = 0; i < 8; i++) wr(osd_pkg::ADDR_OUT_STATE[i], {3'b000, 3'(i), 2'b00});
		for (int i = 0; i < 8; i++) begin
			k  = 3'(i);
			sw = 10'(250 * (i % 4 + 1));
			chk_word("out ctl", {3'h0, 1'b1, k[2], 8'ha5 >> (7 - i) & 8'h01 ? 1'b1 : 1'b0, sw}, 16'(ctl[i]));
			rd_chk(osd_pkg::ADDR_OUT_STATE[i], {3'b000, k, 2'b00});
		end
		wr(osd_pkg::ADDR_OUT_STATE[2], 8'h9c);
		chk_word("power down", 16'h0, {5'h0, ctl[2].powered, ctl[2].swing_mv});
		chk_word("neighbour", {3'h0, 1'b1, 1'b0, 1'b0, 10'd1000}, 16'(ctl[3]));
		$display("test output state done");
		foreach (wa[i]) begin
			wr(wa[i], 8'hff);
			rd_chk(wa[i], wv[i]);
		end
		chk_word("ref fields", 16'h7f00, {1'b0, cfg.ref_win, cfg.ref_div});
		chk_byte("bias", 8'h01, bias);
		wr(8'h00, 8'hef);
		wr(8'h01, 8'hff);
		chk_word("fb div max", 16'h7fff, {1'b0, cfg.fb_win, cfg.fb_div});
		wr(8'h1f, 8'h5a);
		rd_chk(8'h1f, 8'h5a);
		chk_byte("misc", 8'h5a, cfg.misc);
		$display("test register access done");
		wr(8'h04, 8'ha0);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h08);
		wr(8'h02, 8'h08);
		wr(8'h03, 8'h00);
		wr(8'h0c, 8'h00);
		count(64);
		chk_word("fb ticks", 16'd8, 16'(n_fb));
		chk_word("lock samples", 16'd8, 16'(n_lock));
		chk_word("second fb ticks", 16'd8, 16'(n_sfb));
		chk_word("pre ticks bypass", 16'd64, 16'(n_syn));
		wr(8'h00, 8'h10);
		wr(8'h0c, 8'h04);
		count(64);
		chk_word("second fb off", 16'd0, 16'(n_sfb));
		chk_word("fb ticks off", 16'd8, 16'(n_fb));
		chk_word("pre ticks div", 16'd16, 16'(n_syn));
		wr(8'h0c, 8'h84);
		count(64);
		chk_word("pre ticks dbl", 16'd64, 16'(n_syn));
		$display("test divider ticks done");
		stop_test();
	end
endmodule : osd_regs_tb
`default_nettype wire
